// File: bench/npc_field_model.sv
`timescale 1ns/1ps
// remote party: its field reaches the level detector pin off the clock edge
module npc_field_model (
  input  wire logic core_clk,
  input  wire logic fieldReq,
  output logic      extFieldPin
);
  always @(posedge core_clk)
  begin
    extFieldPin <= #3 fieldReq;
  end
endmodule : npc_field_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [2:0] rate; logic frm; logic [7:0] bits; logic ext;} npc_row_t;
  localparam int QUIET = 4;
  logic                 core_clk, sys_rst, clkEn, transBusy, txActive, fieldReq, extFieldPin;
  logic                 detectorEn, initStart, seen;
  logic [7:0]           rdData;
  logic [2:0]           activeRate;
  npc_pkg::npc_bus_t    regBus;
  npc_pkg::npc_coding_t coding;
  npc_row_t             rows [4];
  int                   n_errors, checked, n;

  npc_peer_ctrl #(.QUIET_CYC(QUIET)) npc_peer_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regBus(regBus), .transBusy(transBusy), .txActive(txActive), .extFieldPin(extFieldPin), .rdData(rdData),
    .coding(coding), .detectorEn(detectorEn), .initStart(initStart), .activeRate(activeRate));
  npc_field_model npc_field_model_i (.core_clk(core_clk), .fieldReq(fieldReq), .extFieldPin(extFieldPin));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regBus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regBus.rd <= 1'b0;
    #1 chk(rdData, exp);
  endtask : rdchk

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  initial
  begin
    n_errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    transBusy = 1'b0;
    txActive = 1'b0;
    fieldReq = 1'b0;
    regBus = '0;
    rows[0] = '{3'h0, 1'b1, 8'h80, 1'b0};
    rows[1] = '{3'h1, 1'b0, 8'h40, 1'b0};
    rows[2] = '{3'h2, 1'b0, 8'h20, 1'b0};
    rows[3] = '{3'h3, 1'b0, 8'h00, 1'b1};
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h00);
    chk({7'h00, detectorEn}, 8'h01);
    rdchk(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    rdchk(4'h0, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h2, {1'b0, rows[i].rate, 4'h0});
      repeat (3) @(posedge core_clk);
      #1 chk({5'h00, activeRate}, {5'h00, rows[i].rate});
      chk({7'h00, coding.extPathOnly}, {7'h00, rows[i].ext});
      if (!rows[i].ext)
      begin
        chk({7'h00, coding.framing14443}, {7'h00, rows[i].frm});
        chk(coding.bitCarriers, rows[i].bits);
      end
      rdchk(4'h6, {3'h0, rows[i].rate, 2'h0});
    end
    // rate written inside a transaction must wait for its end
    wr(4'h2, 8'h00);
    transBusy <= 1'b1;
    repeat (2) @(posedge core_clk);
    wr(4'h2, 8'h20);
    repeat (3) @(posedge core_clk);
    #1 chk({5'h00, activeRate}, 8'h00);
    transBusy <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk({5'h00, activeRate}, 8'h02);
    fieldReq <= 1'b1;
    wr(4'h1, 8'h01);
    repeat (20) @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h00);
    rdchk(4'h6, {3'h0, 3'h2, 2'h1});
    fieldReq <= 1'b0;
    seen = 1'b0;
    for (n = 0; n < 40 && !seen; n++)
    begin
      @(posedge core_clk);
      #1 seen = (initStart === 1'b1);
    end
    chk({7'h00, seen}, 8'h01);
    chk({7'h00, n >= QUIET}, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h01);
    chk({7'h00, detectorEn}, 8'h00);
    chk({7'h00, coding.shallowAsk}, 8'h01);
    chk({6'h00, coding.txCode}, 8'h01);
    chk({7'h00, coding.loadMod}, 8'h00);
    wr(4'h1, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h00);
    chk({7'h00, detectorEn}, 8'h01);
    chk({7'h00, coding.loadMod}, 8'h01);
    // card emulation of the 14443A scheme at 424
    wr(4'h1, 8'h0C);
    repeat (3) @(posedge core_clk);
    #1 chk({6'h00, coding.txCode}, 8'h02);
    chk({6'h00, coding.rxCode}, 8'h00);
    chk({7'h00, coding.loadMod}, 8'h01);
    // active target raises its own field only to send
    wr(4'h1, 8'h02);
    txActive <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h01);
    txActive <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, coding.fieldOn}, 8'h00);
    wr(4'h1, 8'h00);
    // other pages hide the control registers
    wr(4'h0, 8'h02);
    wr(4'h2, 8'h10);
    rdchk(4'h2, 8'h00);
    rdchk(4'h0, 8'h02);
    wr(4'h0, 8'h01);
    rdchk(4'h2, 8'h20);
    rdchk(4'h7, 8'h00);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(4'h0, 8'h00);
    conclude();
  end
endmodule : tb_top

// File: src/npc_map.svh
`ifndef NPC_MAP_SVH
`define NPC_MAP_SVH
// register offsets within a page
`define NPC_OFS_PAGE      4'h0
`define NPC_OFS_MODE      4'h1
`define NPC_OFS_TXRATE    4'h2
`define NPC_OFS_RXRATE    4'h3
`define NPC_OFS_DRVLOGIC  4'h4
`define NPC_OFS_DRVAUTO   4'h5
`define NPC_OFS_STATUS    4'h6
`define NPC_PAGE_CMD      2'h1
// field positions
`define NPC_MODE_INIT_BIT   0
`define NPC_MODE_ACTIVE_BIT 1
`define NPC_MODE_CARD_BIT   2
`define NPC_RATE_LSB        4
`define NPC_RATE_MSB        6
`define NPC_DRV_ON_BIT      0
`define NPC_RATE_106        3'h0
`define NPC_RATE_212        3'h1
`define NPC_RATE_424        3'h2
// reset values
`define NPC_RST_PAGE      2'h0
`define NPC_RST_BYTE      8'h00
// timing: quiet interval in microseconds, clock period in ns
`define NPC_QUIET_US      5
`define NPC_CLK_NS        20
`define NPC_QUIET_CYC     ((`NPC_QUIET_US * 1000 + `NPC_CLK_NS - 1) / `NPC_CLK_NS)
`endif

// File: src/npc_peer_ctrl.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "npc_map.svh"
module npc_peer_ctrl #(
  parameter int QUIET_CYC = `NPC_QUIET_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                clkEn,
  input  wire npc_pkg::npc_bus_t   regBus,
  input  wire logic                transBusy,
  input  wire logic                txActive,
  input  wire logic                extFieldPin,
  output logic [7:0]               rdData,
  output npc_pkg::npc_coding_t     coding,
  output logic                     detectorEn,
  output logic                     initStart,
  output logic [2:0]               activeRate
);
  npc_pkg::npc_state_t st_reg;
  npc_pkg::npc_state_t st_next;
  logic initReq;
  logic activeMode;
  logic cardMode;
  logic [2:0] reqRate;

  assign initReq    = st_reg.mode[`NPC_MODE_INIT_BIT];
  assign activeMode = st_reg.mode[`NPC_MODE_ACTIVE_BIT];
  assign cardMode   = st_reg.mode[`NPC_MODE_CARD_BIT];
  assign reqRate    = st_reg.txRate[`NPC_RATE_MSB:`NPC_RATE_LSB];

  always_comb
  begin
    st_next = st_reg;
    st_next.fldSync1 = extFieldPin;
    st_next.fldSync2 = st_reg.fldSync1;
    st_next.inTrans  = transBusy;
    st_next.rdData   = 8'h00;
    if (regBus.wr)
    begin
      if (regBus.addr == `NPC_OFS_PAGE)
        st_next.page = regBus.wdata[1:0];
      else if (st_reg.page == `NPC_PAGE_CMD)
      begin
        unique case (regBus.addr)
          `NPC_OFS_MODE:     st_next.mode = regBus.wdata;
          `NPC_OFS_TXRATE:   st_next.txRate = regBus.wdata;
          `NPC_OFS_RXRATE:   st_next.rxRate = regBus.wdata;
          `NPC_OFS_DRVLOGIC: st_next.drvLogic = regBus.wdata;
          `NPC_OFS_DRVAUTO:  st_next.drvAuto = regBus.wdata;
          default:           st_next.drvAuto = st_reg.drvAuto;
        endcase
      end
    end
    if (regBus.rd)
    begin
      if (regBus.addr == `NPC_OFS_PAGE)
        st_next.rdData = {6'h00, st_reg.page};
      else if (st_reg.page == `NPC_PAGE_CMD)
      begin
        unique case (regBus.addr)
          `NPC_OFS_MODE:     st_next.rdData = st_reg.mode;
          `NPC_OFS_TXRATE:   st_next.rdData = st_reg.txRate;
          `NPC_OFS_RXRATE:   st_next.rdData = st_reg.rxRate;
          `NPC_OFS_DRVLOGIC: st_next.rdData = st_reg.drvLogic;
          `NPC_OFS_DRVAUTO:  st_next.rdData = st_reg.drvAuto;
          `NPC_OFS_STATUS:   st_next.rdData = {3'h0, st_reg.activeRate, st_reg.role};
          default:           st_next.rdData = 8'h00;
        endcase
      end
    end
    // rate latched only while no transaction runs
    if (!st_reg.inTrans)
      st_next.activeRate = reqRate;
    unique case (st_reg.role)
      npc_pkg::ROLE_TARGET:
      begin
        st_next.quietCnt = 16'h0000;
        if (initReq && !cardMode)
          st_next.role = npc_pkg::ROLE_LISTEN;
      end
      npc_pkg::ROLE_LISTEN:
      begin
        if (!initReq)
          st_next.role = npc_pkg::ROLE_TARGET;
        else if (st_reg.fldSync2)
          st_next.quietCnt = 16'h0000;
        else if (st_reg.quietCnt == 16'(QUIET_CYC - 1))
          st_next.role = npc_pkg::ROLE_INIT;
        else
          st_next.quietCnt = st_reg.quietCnt + 16'h0001;
      end
      npc_pkg::ROLE_INIT:
        if (!initReq)
          st_next.role = npc_pkg::ROLE_TARGET;
      // code 3 is illegal: fall back to the safe target role
      default:
        st_next.role = npc_pkg::ROLE_TARGET;
    endcase
    // coding selection from the rate in force
    st_next.coding = '0;
    st_next.coding.extPathOnly = (st_reg.activeRate > `NPC_RATE_424);
    unique case (st_reg.activeRate)
      `NPC_RATE_106: st_next.coding.bitCarriers = 8'h80;
      `NPC_RATE_212: st_next.coding.bitCarriers = 8'h40;
      default:       st_next.coding.bitCarriers = 8'h20;
    endcase
    if (st_reg.activeRate == `NPC_RATE_106)
    begin
      st_next.coding.framing14443 = 1'b1;
      st_next.coding.txCode = npc_pkg::CODE_MILLER;
      st_next.coding.rxCode = npc_pkg::CODE_MILLER;
      if (cardMode || (!activeMode && st_reg.role == npc_pkg::ROLE_TARGET))
        st_next.coding.txCode = npc_pkg::CODE_MANCH;
      else if (st_reg.role == npc_pkg::ROLE_TARGET && activeMode)
        st_next.coding.rxCode = npc_pkg::CODE_MILLER;
      if (st_reg.role != npc_pkg::ROLE_TARGET)
        st_next.coding.rxCode = npc_pkg::CODE_MANCH;
    end
    else if (cardMode && st_reg.mode[3])
    begin
      // 14443A card emulation at higher rates
      st_next.coding.framing14443 = 1'b1;
      st_next.coding.rxCode = npc_pkg::CODE_MILLER;
      st_next.coding.txCode = npc_pkg::CODE_BPSK;
    end
    else
    begin
      st_next.coding.framing14443 = 1'b0;
      st_next.coding.txCode = npc_pkg::CODE_MANCH;
      st_next.coding.rxCode = npc_pkg::CODE_MANCH;
      st_next.coding.shallowAsk = (st_reg.role == npc_pkg::ROLE_INIT) && !activeMode;
    end
    // field and load modulation policy
    if (st_reg.role == npc_pkg::ROLE_INIT)
      st_next.coding.fieldOn = activeMode ? txActive : 1'b1;
    else
      st_next.coding.fieldOn = activeMode && txActive && !cardMode;
    st_next.coding.loadMod = (st_reg.role == npc_pkg::ROLE_TARGET) && (!activeMode || cardMode);
    if (sys_rst)
    begin
      st_next = '0;
      st_next.role = npc_pkg::ROLE_TARGET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clkEn)
      st_reg <= st_next;
  end

  logic initPulse_reg;
  logic initPulse_next;
  assign initPulse_next = (st_reg.role == npc_pkg::ROLE_LISTEN) && (st_next.role == npc_pkg::ROLE_INIT);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      initPulse_reg <= 1'b0;
    else if (clkEn)
      initPulse_reg <= initPulse_next;
  end

  logic detEn_reg;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      detEn_reg <= 1'b1;
    else if (clkEn)
      detEn_reg <= (st_next.role != npc_pkg::ROLE_INIT);
  end

  assign rdData     = st_reg.rdData;
  assign coding     = st_reg.coding;
  assign activeRate = st_reg.activeRate;
  assign initStart  = initPulse_reg;
  assign detectorEn = detEn_reg;

  field_off_target_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && st_reg.role == npc_pkg::ROLE_TARGET && !st_reg.mode[`NPC_MODE_ACTIVE_BIT]) |=> !coding.fieldOn)
    else $error("field on in passive target");
  quiet_before_init_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && st_reg.role == npc_pkg::ROLE_LISTEN && st_reg.fldSync2) |=> st_reg.role != npc_pkg::ROLE_INIT)
    else $error("initiator entered while field sensed");
  rate_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.inTrans && clkEn) |=> $stable(st_reg.activeRate))
    else $error("rate changed inside transaction");
  detector_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.role == npc_pkg::ROLE_TARGET) |=> ##1 detectorEn || st_reg.role == npc_pkg::ROLE_INIT)
    else $error("detector off in target role");
  low_rate_framing_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && st_reg.activeRate == `NPC_RATE_106) |=> coding.framing14443)
    else $error("wrong framing at lowest rate");
  high_rate_framing_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && st_reg.activeRate == `NPC_RATE_212 && !st_reg.mode[`NPC_MODE_CARD_BIT]) |=> !coding.framing14443)
    else $error("wrong framing at higher rate");
  ext_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && st_reg.activeRate > `NPC_RATE_424) |=> coding.extPathOnly)
    else $error("fast rate not flagged");
  init_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    initStart |-> $past(st_reg.role) == npc_pkg::ROLE_LISTEN || !clkEn)
    else $error("init start without quiet wait");
  page_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clkEn && regBus.wr && regBus.addr == `NPC_OFS_PAGE) |=> st_reg.page == $past(regBus.wdata[1:0]))
    else $error("page selector not written");
endmodule : npc_peer_ctrl

// File: src/npc_pkg.sv
package npc_pkg;
  typedef enum logic [1:0] {CODE_MILLER, CODE_MANCH, CODE_BPSK} npc_code_t;
  typedef enum logic [1:0] {ROLE_TARGET, ROLE_LISTEN, ROLE_INIT} npc_role_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } npc_bus_t;
  typedef struct packed {
    logic      framing14443;  // 1: 14443A framing, 0: preamble/sync framing
    npc_code_t txCode;
    npc_code_t rxCode;
    logic      shallowAsk;    // 8-30 % modulation depth
    logic      loadMod;       // answer by load modulation
    logic      fieldOn;
    logic      extPathOnly;   // rate needs external circuitry
    logic [7:0] bitCarriers;  // carrier periods per bit
  } npc_coding_t;
  typedef struct packed {
    logic [1:0]  page;
    logic [7:0]  mode;
    logic [7:0]  txRate;
    logic [7:0]  rxRate;
    logic [7:0]  drvLogic;
    logic [7:0]  drvAuto;
    logic [2:0]  activeRate;
    npc_role_t   role;
    logic [15:0] quietCnt;
    logic        fldSync1;
    logic        fldSync2;
    logic        inTrans;
    logic [7:0]  rdData;
    npc_coding_t coding;
  } npc_state_t;
endpackage : npc_pkg
